// ---- hw/pcx_port_io.sv ----
`timescale 1ns/1ps
// What this block does
// - each selected function other than the serial port takes the lowest free crossbar pin, in priority
// - serial transmit always on port 0 bit 4, receive on bit 5
// - a pin already handed out is passed over for later functions
// - a skipped pin is treated as already assigned
// - only port 0 bit 0 through port 2 bit 3 join the crossbar
// - two-wire bus takes both pins; serial port takes both pins
// - pins left over stay ordinary port bits
// - SPI slave select claims a pin only in 4-wire mode
// - port reads return the pin level whatever the routing; analog pins read as one
// - input mode bit one means digital input, zero means analog
// - after reset every pin is a digital input
// - analog pins lose pull-up, output driver and digital receiver
// - output type comes from the per-pin output type bit, except on two-wire bus pins
// - two-wire bus pins are always open drain
// - open-drain pins get pull-up unless the global disable bit is set
// - pull-up is off while the pin drives low
// - while routing is disabled all pins are port bits in input mode
// - while routing is disabled all output drivers are off
// - counter field routes zero to five capture channels
// - timer zero input routed only when its enable bit is set
module pcx_port_io
    import pcx_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic clkEn,
    // configuration, latched on cfgWrite
    input wire logic cfgWrite,
    input wire logic [SEL_W-1:0] periphRouteSelA,
    input wire logic [SEL_W-1:0] periphRouteSelB,
    input wire logic [XB_PINS-1:0] pinSkipMask,
    input wire logic [ALL_PINS-1:0] pinInputMode,
    input wire logic [ALL_PINS-1:0] pinOutputType,
    input wire logic [SPI_MODE_W-1:0] spiSelectModeField,
    // status
    output logic routeGlobalEnable,
    output logic pullupGlobalDisable,
    // port latch and port read
    input wire logic [ALL_PINS-1:0] portLatch,
    output logic [ALL_PINS-1:0] portReadLevel,
    // peripheral side
    input wire logic [NUM_FUNCS-1:0] periphOut,
    input wire logic [NUM_FUNCS-1:0] periphDrive,
    output logic [NUM_FUNCS-1:0] periphIn,
    // package pins
    input wire logic [ALL_PINS-1:0] pinIn,
    output logic [ALL_PINS-1:0] pinOut,
    output logic [ALL_PINS-1:0] pinOutEnable,
    output logic [ALL_PINS-1:0] pinPullupEnable,
    output logic [ALL_PINS-1:0] pinReceiverEnable
);

logic [SEL_W-1:0] selA;
logic [SEL_W-1:0] selB;
logic [XB_PINS-1:0] skipReg;
logic [ALL_PINS-1:0] inModeReg;
logic [ALL_PINS-1:0] outTypeReg;
logic [SPI_MODE_W-1:0] spiModeReg;
logic [ALL_PINS-1:0] pinMeta;
logic [ALL_PINS-1:0] pinSync;
logic xbarEn;
logic pullupDis;
logic fourWire;
logic [PCA_FIELD_W-1:0] pcaField;
logic [NUM_FUNCS-1:0] funcEnable;
logic [ALL_PINS-1:0] ownedMask;
logic [ALL_PINS-1:0] smbMask;
logic [ALL_PINS-1:0] drvValue;
logic [ALL_PINS-1:0] drvWant;
logic [ALL_PINS-1:0] odMask;
logic [ALL_PINS-1:0] lowDrive;
logic [ALL_PINS-1:0] next_pinOut;
logic [ALL_PINS-1:0] next_pinOutEnable;
logic [ALL_PINS-1:0] next_pinPullupEnable;
logic [ALL_PINS-1:0] next_pinReceiverEnable;
logic [XB_PINS-1:0] uartPins;

pcx_route_if route ();

pcx_route_decoder u_decoder (
    .route(route.decoder)
);

// ==========================================================
// configuration registers
always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        selA <= SEL_RST;
        selB <= SEL_RST;
        skipReg <= SKIP_RST;
        inModeReg <= IN_MODE_RST;
        outTypeReg <= OUT_TYPE_RST;
        spiModeReg <= SPI_THREE_WIRE;
    end else if (clkEn && cfgWrite) begin
        selA <= periphRouteSelA;
        selB <= periphRouteSelB;
        skipReg <= pinSkipMask;
        inModeReg <= pinInputMode;
        outTypeReg <= pinOutputType;
        spiModeReg <= spiSelectModeField;
    end
end

always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        routeGlobalEnable <= 1'b0;
        pullupGlobalDisable <= 1'b0;
    end else if (clkEn) begin
        routeGlobalEnable <= xbarEn;
        pullupGlobalDisable <= pullupDis;
    end
end

// ==========================================================
// pin synchroniser
always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        pinMeta <= PIN_RST;
        pinSync <= PIN_RST;
    end else if (clkEn) begin
        pinMeta <= pinIn;
        pinSync <= pinMeta;
    end
end

// ==========================================================
// function enables seen by the decoder
assign xbarEn = selB[SB_ENABLE];
assign pullupDis = selB[SB_PULLUP_DIS];
assign pcaField = selB[SB_PCA_LSB +: PCA_FIELD_W];
assign fourWire = (spiModeReg != SPI_THREE_WIRE);

always_comb begin
    funcEnable = '0;
    funcEnable[F_UART_TX] = selA[SA_UART];
    funcEnable[F_UART_RX] = selA[SA_UART];
    funcEnable[F_SPI_SCK] = selA[SA_SPI];
    funcEnable[F_SPI_MISO] = selA[SA_SPI];
    funcEnable[F_SPI_MOSI] = selA[SA_SPI];
    funcEnable[F_SPI_SEL] = selA[SA_SPI] && fourWire;
    funcEnable[F_SMB_SDA] = selA[SA_SMB];
    funcEnable[F_SMB_SCL] = selA[SA_SMB];
    funcEnable[F_CMP0] = selA[SA_CMP0];
    funcEnable[F_CMP0_ASYNC] = selA[SA_CMP0_ASYNC];
    funcEnable[F_CMP1] = selA[SA_CMP1];
    funcEnable[F_CMP1_ASYNC] = selA[SA_CMP1_ASYNC];
    funcEnable[F_SYSCLK] = selA[SA_SYSCLK];
    for (int k = 0; k < CEX_COUNT; k++) begin
        funcEnable[F_CAPTURE_CHANNEL_LINE + k] = (pcaField > PCA_FIELD_W'(k));
    end
    funcEnable[F_ECI] = selB[SB_ECI];
    funcEnable[F_T0] = selB[SB_T0];
    funcEnable[F_T1] = selB[SB_T1];
    if (!xbarEn) begin
        funcEnable = '0;
    end
end

assign route.funcEnable = funcEnable;
assign route.skipMask = skipReg;

// ==========================================================
// per-pin source: peripheral or port latch
always_comb begin
    ownedMask = '0;
    smbMask = '0;
    drvValue = portLatch;
    drvWant = '1;
    for (int p = 0; p < XB_PINS; p++) begin
        for (int f = 0; f < NUM_FUNCS; f++) begin
            if (route.ownerOf[p] == pcx_code(f)) begin
                ownedMask[p] = 1'b1;
                drvValue[p] = periphOut[f];
                drvWant[p] = periphDrive[f];
                smbMask[p] = (f == F_SMB_SDA) || (f == F_SMB_SCL);
            end
        end
    end
end

// ==========================================================
// driver, pull-up and receiver control
assign odMask = ~outTypeReg | smbMask;
assign next_pinOutEnable = {ALL_PINS{xbarEn}} & inModeReg & drvWant
    & (~odMask | ~drvValue);
assign next_pinOut = ~odMask & drvValue;
assign lowDrive = next_pinOutEnable & ~next_pinOut;
assign next_pinPullupEnable = inModeReg & odMask
    & {ALL_PINS{~pullupDis}} & ~lowDrive;
assign next_pinReceiverEnable = inModeReg;

always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        pinOut <= PIN_RST;
        pinOutEnable <= PIN_RST;
        pinPullupEnable <= PIN_RST;
        pinReceiverEnable <= IN_MODE_RST;
    end else if (clkEn) begin
        pinOut <= next_pinOut;
        pinOutEnable <= next_pinOutEnable;
        pinPullupEnable <= next_pinPullupEnable;
        pinReceiverEnable <= next_pinReceiverEnable;
    end
end

// ==========================================================
// port read and peripheral inputs
always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        portReadLevel <= READ_RST;
    end else if (clkEn) begin
        // analog pins read as one
        portReadLevel <= pinSync | ~inModeReg;
    end
end

always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
        periphIn <= PERIPH_IN_RST;
    end else if (clkEn) begin
        for (int f = 0; f < NUM_FUNCS; f++) begin
            // unplaced inputs idle high
            periphIn[f] <= route.funcPlaced[f]
                ? pinSync[route.funcPin[f]] : 1'b1;
        end
    end
end

// ==========================================================
// checks
assign uartPins = route.funcPlaced[F_UART_TX]
    ? (XB_PINS'(1) << UART_TX_PIN) | (XB_PINS'(1) << UART_RX_PIN)
    : '0;

default clocking @(posedge sys_clk); endclocking
default disable iff (!reset_n);

uart_fixed_pins_a: assert property (
    (xbarEn && selA[SA_UART])
    |-> (route.ownerOf[UART_TX_PIN] == pcx_code(F_UART_TX))
        && (route.ownerOf[UART_RX_PIN] == pcx_code(F_UART_RX)))
    else $error("serial port not on its fixed pins");

skip_pin_free_a: assert property (
    (skipReg & ownedMask[XB_PINS-1:0] & ~uartPins) == '0)
    else $error("skipped pin was assigned");

no_route_off_a: assert property (
    !xbarEn |-> (ownedMask == '0) && (route.funcPlaced == '0))
    else $error("pin routed while routing disabled");

drivers_off_a: assert property (
    (clkEn && !xbarEn) |=> (pinOutEnable == '0))
    else $error("driver on while routing disabled");

analog_pin_quiet_a: assert property (
    clkEn |=> ((pinOutEnable | pinPullupEnable | pinReceiverEnable)
        & ~$past(inModeReg)) == '0)
    else $error("analog pin has digital path active");

smb_open_drain_a: assert property (
    clkEn |=> (pinOut & $past(smbMask)) == '0)
    else $error("two-wire pin driven high");

pullup_low_off_a: assert property (
    (pinPullupEnable & pinOutEnable & ~pinOut) == '0)
    else $error("pull-up on while driving low");

select_three_wire_a: assert property (
    (spiModeReg == SPI_THREE_WIRE) |-> !route.funcPlaced[F_SPI_SEL])
    else $error("slave select placed in 3-wire mode");

channels_none_a: assert property (
    (pcaField == '0) |-> (route.funcPlaced[F_CAPTURE_CHANNEL_LINE +: CEX_COUNT] == '0))
    else $error("capture channel placed with field zero");

lowest_first_a: assert property (
    route.funcPlaced[F_SPI_SCK]
    |-> (route.funcPin[F_SPI_SCK] == '0) || skipReg[0])
    else $error("first function not on lowest free pin");

pull_enable_a: assert property (
    clkEn |=> (($past(inModeReg & odMask & ~lowDrive)
        & ~pinPullupEnable) == '0) || $past(pullupDis))
    else $error("open-drain pin lacks pull-up");

crossbar_pins_only_a: assert property (
    route.funcPlaced[F_T0]
    |-> (route.funcPin[F_T0] < FUNC_W'(XB_PINS)))
    else $error("function placed outside crossbar pins");

two_wire_pair_a: assert property (
    route.funcPlaced[F_SMB_SCL]
    |-> route.funcPlaced[F_SMB_SDA]
        && (route.funcPin[F_SMB_SCL] > route.funcPin[F_SMB_SDA]))
    else $error("two-wire clock placed without data");

clock_after_cmp_a: assert property (
    (route.funcPlaced[F_SYSCLK] && route.funcPlaced[F_CMP0])
    |-> (route.funcPin[F_SYSCLK] > route.funcPin[F_CMP0]))
    else $error("clock output ahead of comparator");

timer_unrouted_a: assert property (
    !selB[SB_T0] |-> !route.funcPlaced[F_T0])
    else $error("timer input placed while not enabled");

gpio_follow_a: assert property (
    clkEn |=> pinOut[ALL_PINS-1]
        == ($past(portLatch[ALL_PINS-1]) && $past(outTypeReg[ALL_PINS-1])))
    else $error("spare pin does not follow port latch");

receiver_mode_a: assert property (
    clkEn |=> (pinReceiverEnable == $past(inModeReg)))
    else $error("receiver does not follow input mode");

read_analog_a: assert property (
    clkEn |=> ((portReadLevel | $past(inModeReg)) == '1))
    else $error("analog pin does not read as one");

config_frozen_a: assert property (
    !clkEn |=> $stable(selB) && $stable(inModeReg))
    else $error("settings changed while clock disabled");

open_drain_high_a: assert property (
    clkEn |=> ((pinOut & ~$past(outTypeReg)) == '0))
    else $error("open-drain pin driven high");

push_pull_pull_a: assert property (
    clkEn |=> ((pinPullupEnable & $past(outTypeReg & ~smbMask)) == '0))
    else $error("pull-up on a push-pull pin");

channels_all_a: assert property (
    (xbarEn && (skipReg == '0) && (pcaField >= PCA_FIELD_W'(CEX_COUNT)))
    |-> (&route.funcPlaced[F_CAPTURE_CHANNEL_LINE +: CEX_COUNT]))
    else $error("not all capture channels placed");

endmodule

// ---- hw/pcx_route_decoder.sv ----
`timescale 1ns/1ps
module pcx_route_decoder
    import pcx_pkg::*;
(
    // settings in, assignments out
    pcx_route_if.decoder route
);

logic [XB_PINS-1:0] taken;
logic found;

// ==========================================================
// priority placement
always_comb begin
    taken = route.skipMask;
    found = 1'b0;
    route.ownerOf = '0;
    route.funcPin = '0;
    route.funcPlaced = '0;
    // serial port sits on its fixed pair, skip mask or not
    if (route.funcEnable[F_UART_TX]) begin
        route.ownerOf[UART_TX_PIN] = pcx_code(F_UART_TX);
        route.ownerOf[UART_RX_PIN] = pcx_code(F_UART_RX);
        route.funcPin[F_UART_TX] = FUNC_W'(UART_TX_PIN);
        route.funcPin[F_UART_RX] = FUNC_W'(UART_RX_PIN);
        route.funcPlaced[F_UART_TX] = 1'b1;
        route.funcPlaced[F_UART_RX] = 1'b1;
        taken[UART_TX_PIN] = 1'b1;
        taken[UART_RX_PIN] = 1'b1;
    end
    // only the crossbar pins are searched
    for (int f = F_SPI_SCK; f < NUM_FUNCS; f++) begin
        found = 1'b0;
        for (int p = 0; p < XB_PINS; p++) begin
            if (route.funcEnable[f] && !found && !taken[p]) begin
                found = 1'b1;
                taken[p] = 1'b1;
                route.ownerOf[p] = pcx_code(f);
                route.funcPin[f] = FUNC_W'(p);
                route.funcPlaced[f] = 1'b1;
            end
        end
    end
end

endmodule

// ---- pkg/pcx_pkg.sv ----
package pcx_pkg;

// ==========================================================
// pin counts and widths
localparam int XB_PINS = 20;
localparam int ALL_PINS = 29;
localparam int NUM_FUNCS = 21;
localparam int FUNC_W = 5;
localparam int SEL_W = 8;
localparam int SPI_MODE_W = 2;
localparam int PCA_FIELD_W = 3;
localparam int CEX_COUNT = 5;

// ==========================================================
// fixed serial pins
localparam int UART_TX_PIN = 4;
localparam int UART_RX_PIN = 5;

// ==========================================================
// function indices in priority order
localparam int F_UART_TX = 0;
localparam int F_UART_RX = 1;
localparam int F_SPI_SCK = 2;
localparam int F_SPI_MISO = 3;
localparam int F_SPI_MOSI = 4;
localparam int F_SPI_SEL = 5;
localparam int F_SMB_SDA = 6;
localparam int F_SMB_SCL = 7;
localparam int F_CMP0 = 8;
localparam int F_CMP0_ASYNC = 9;
localparam int F_CMP1 = 10;
localparam int F_CMP1_ASYNC = 11;
localparam int F_SYSCLK = 12;
localparam int F_CAPTURE_CHANNEL_LINE = 13;
localparam int F_ECI = 18;
localparam int F_T0 = 19;
localparam int F_T1 = 20;

// ==========================================================
// route select A bit positions
localparam int SA_UART = 0;
localparam int SA_SPI = 1;
localparam int SA_SMB = 2;
localparam int SA_SYSCLK = 3;
localparam int SA_CMP0 = 4;
localparam int SA_CMP0_ASYNC = 5;
localparam int SA_CMP1 = 6;
localparam int SA_CMP1_ASYNC = 7;

// ==========================================================
// route select B bit positions
localparam int SB_PCA_LSB = 0;
localparam int SB_ECI = 3;
localparam int SB_T0 = 4;
localparam int SB_T1 = 5;
localparam int SB_ENABLE = 6;
localparam int SB_PULLUP_DIS = 7;

// ==========================================================
// codes and reset values
localparam logic [SPI_MODE_W-1:0] SPI_THREE_WIRE = 2'h0;
localparam logic [FUNC_W-1:0] OWNER_GPIO = 5'h00;
localparam logic [SEL_W-1:0] SEL_RST = 8'h00;
localparam logic [XB_PINS-1:0] SKIP_RST = 20'h00000;
localparam logic [ALL_PINS-1:0] IN_MODE_RST = 29'h1FFFFFFF;
localparam logic [ALL_PINS-1:0] OUT_TYPE_RST = 29'h00000000;
localparam logic [ALL_PINS-1:0] PIN_RST = 29'h00000000;
localparam logic [ALL_PINS-1:0] READ_RST = 29'h1FFFFFFF;
localparam logic [NUM_FUNCS-1:0] PERIPH_IN_RST = 21'h1FFFFF;

// owner code of a function, zero meaning plain port bit
function automatic logic [FUNC_W-1:0] pcx_code(input int f);
    return FUNC_W'(f + 1);
endfunction

endpackage

// ---- pkg/pcx_route_if.sv ----
`timescale 1ns/1ps
interface pcx_route_if;
    import pcx_pkg::*;
    logic [NUM_FUNCS-1:0] funcEnable;
    logic [XB_PINS-1:0] skipMask;
    logic [XB_PINS-1:0][FUNC_W-1:0] ownerOf;
    logic [NUM_FUNCS-1:0][FUNC_W-1:0] funcPin;
    logic [NUM_FUNCS-1:0] funcPlaced;

    modport decoder (
        input funcEnable,
        input skipMask,
        output ownerOf,
        output funcPin,
        output funcPlaced
    );
    modport core (
        output funcEnable,
        output skipMask,
        input ownerOf,
        input funcPin,
        input funcPlaced
    );
endinterface

// ---- verif/pcx_pin_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// package pins as seen from the board
module pcx_pin_model
    import pcx_pkg::*;
(
    // clock
    input wire logic sys_clk,
    // pin controls from the block
    input wire logic [ALL_PINS-1:0] pinOut,
    input wire logic [ALL_PINS-1:0] pinOutEnable,
    input wire logic [ALL_PINS-1:0] pinPullupEnable,
    // board drivers
    input wire logic [ALL_PINS-1:0] extDrive,
    input wire logic [ALL_PINS-1:0] extValue,
    // resolved levels
    output logic [ALL_PINS-1:0] pinIn
);
    // an undriven pin without pull-up wanders every cycle
    logic [ALL_PINS-1:0] floatPat = '0;

    always_ff @(posedge sys_clk) begin
        floatPat <= ~floatPat;
    end

    always_comb begin
        for (int p = 0; p < ALL_PINS; p++) begin
            if (pinOutEnable[p]) begin
                pinIn[p] = pinOut[p];
            end else if (extDrive[p]) begin
                pinIn[p] = extValue[p];
            end else if (pinPullupEnable[p]) begin
                pinIn[p] = 1'b1;
            end else begin
                pinIn[p] = floatPat[p];
            end
        end
    end
endmodule

// ---- verif/tb.sv ----
`timescale 1ns/1ps
module tb
    import pcx_pkg::*;
;
    typedef logic [ALL_PINS-1:0] pcx_pins_t;
    logic sys_clk = 0, reset_n = 0, clkEn = 1, cfgWrite = 0;
    logic [SEL_W-1:0] selA = 8'h00, selB = 8'h00;
    logic [XB_PINS-1:0] skip = 20'h00000;
    logic [SPI_MODE_W-1:0] spiMode = 2'h0;
    pcx_pins_t inMode = 29'h1FFFFFFF, outType = 29'h00000000;
    pcx_pins_t portLatch = 29'h1FFFFFFF, extDrive = '0, extValue = '0;
    pcx_pins_t portReadLevel, pinIn, pinOut, pinOutEnable;
    pcx_pins_t pinPullupEnable, pinReceiverEnable;
    logic [NUM_FUNCS-1:0] periphOut = '0, periphDrive = '0, periphIn;
    logic routeGlobalEnable, pullupGlobalDisable;
    int fail_count = 0, samples_checked = 0;

    always #10 sys_clk = ~sys_clk;

    pcx_port_io dut_u (.sys_clk(sys_clk), .reset_n(reset_n),
        .clkEn(clkEn), .cfgWrite(cfgWrite), .periphRouteSelA(selA),
        .periphRouteSelB(selB), .pinSkipMask(skip),
        .pinInputMode(inMode), .pinOutputType(outType),
        .spiSelectModeField(spiMode),
        .routeGlobalEnable(routeGlobalEnable),
        .pullupGlobalDisable(pullupGlobalDisable),
        .portLatch(portLatch), .portReadLevel(portReadLevel),
        .periphOut(periphOut), .periphDrive(periphDrive),
        .periphIn(periphIn), .pinIn(pinIn), .pinOut(pinOut),
        .pinOutEnable(pinOutEnable), .pinPullupEnable(pinPullupEnable),
        .pinReceiverEnable(pinReceiverEnable));

    pcx_pin_model far_u (.sys_clk(sys_clk), .pinOut(pinOut),
        .pinOutEnable(pinOutEnable), .pinPullupEnable(pinPullupEnable),
        .extDrive(extDrive), .extValue(extValue), .pinIn(pinIn));

    // ==========================================================
    // helpers
    task automatic tick(int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic chk(string what, pcx_pins_t exp, pcx_pins_t got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask

    task automatic chk1(string what, logic exp, logic got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s exp %b got %b", what, exp, got);
        end
    endtask

    // selects and skip mask latched together in one write, then two cycles to settle
    task automatic apply(logic [7:0] a, logic [7:0] b, logic [19:0] s);
        selA = a;
        selB = b;
        skip = s;
        cfgWrite = 1;
        tick(1);
        cfgWrite = 0;
        tick(2);
    endtask

    // drive one function low: its pin alone pulls low
    task automatic place(int f, int pin);
        pcx_pins_t exp;
        periphDrive = NUM_FUNCS'(1) << f;
        tick(2);
        exp = (pin < 0) ? '0 : ALL_PINS'(1) << pin;
        chk("placed pin", exp, pinOutEnable);
        periphDrive = '0;
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_reset();
        chk("oe", '0, pinOutEnable);
        chk("pullup", '1, pinPullupEnable);
        chk("receiver", '1, pinReceiverEnable);
        chk1("enable", 1'b0, routeGlobalEnable);
    endtask

    task automatic t_disabled();
        portLatch = '0;
        apply(8'h01, 8'h07, 20'h00000);
        place(F_UART_TX, -1);
        portLatch = '1;
    endtask

    task automatic t_uart();
        apply(8'h01, 8'h40, 20'h00030);
        chk1("enable", 1'b1, routeGlobalEnable);
        place(F_UART_TX, UART_TX_PIN);
        periphDrive[F_UART_TX] = 1;
        tick(2);
        chk1("tx pullup", 1'b0, pinPullupEnable[UART_TX_PIN]);
        periphDrive = '0;
        extDrive[UART_RX_PIN] = 1;
        tick(3);
        chk1("rx in", 1'b0, periphIn[F_UART_RX]);
        chk1("rx read", 1'b0, portReadLevel[UART_RX_PIN]);
        extDrive = '0;
    endtask

    // writes while the clock enable is low are ignored
    task automatic t_freeze();
        clkEn = 0;
        apply(8'h00, 8'h00, 20'h00000);
        clkEn = 1;
        tick(2);
        chk1("frozen enable", 1'b1, routeGlobalEnable);
        place(F_UART_TX, UART_TX_PIN);
    endtask

    task automatic t_priority();
        int fs[10] = '{2, 3, 4, 5, 6, 7, 8, 12, 19, 20};
        int e4[10] = '{0, 1, 6, 7, 8, 9, 10, 11, 12, -1};
        int e3[10] = '{0, 1, 6, -1, 7, 8, 9, 10, 11, -1};
        for (int m = 0; m < 2; m++) begin
            spiMode = (m == 0) ? 2'h1 : SPI_THREE_WIRE;
            apply(8'h1F, 8'h50, 20'h0C00C);
            for (int i = 0; i < 10; i++) begin
                place(fs[i], (m == 0) ? e4[i] : e3[i]);
            end
            portLatch[13] = 0;
            tick(2);
            chk("gpio", 29'h00002000, pinOutEnable);
            portLatch = '1;
        end
    endtask

    task automatic t_channels();
        for (int k = 0; k < 8; k++) begin
            apply(8'h01, 8'h40 | 8'(k), 20'h00000);
            for (int j = 0; j < CEX_COUNT; j++) begin
                place(F_CAPTURE_CHANNEL_LINE + j, j < k ? (j < 4 ? j : j + 2) : -1);
            end
        end
        apply(8'h00, 8'h40, 20'h00000);
        place(F_T0, -1);
    endtask

    task automatic t_bounds();
        apply(8'h03, 8'h40, 20'hFFFFF);
        place(F_UART_TX, UART_TX_PIN);
        place(F_SPI_SCK, -1);
    endtask

    task automatic t_modes();
        outType = '1;
        inMode[10] = 0;
        extDrive[10] = 1;
        apply(8'h04, 8'h40, 20'h00400);
        periphOut[F_SMB_SDA] = 1;
        periphDrive[F_SMB_SDA] = 1;
        tick(3);
        chk1("sda oe", 1'b0, pinOutEnable[0]);
        chk1("sda out", 1'b0, pinOut[0]);
        chk1("pp out", 1'b1, pinOut[2]);
        chk1("sda pullup", 1'b1, pinPullupEnable[0]);
        chk1("pp oe", 1'b1, pinOutEnable[2]);
        chk1("pp pullup", 1'b0, pinPullupEnable[2]);
        chk1("an oe", 1'b0, pinOutEnable[10]);
        chk1("an pullup", 1'b0, pinPullupEnable[10]);
        chk1("an rx", 1'b0, pinReceiverEnable[10]);
        chk1("an read", 1'b1, portReadLevel[10]);
        periphDrive = '0;
        periphOut = '0;
        outType = '0;
        apply(8'h00, 8'hC0, 20'h00000);
        chk1("disable", 1'b1, pullupGlobalDisable);
        chk1("od off", 1'b0, pinPullupEnable[3]);
        inMode = '1;
        extDrive = '0;
    endtask

    initial begin
        #1000000;
        fail_count++;
        conclude();
    end

    initial begin
        tick(20);
        reset_n = 1;
        tick(1);
        t_reset();
        t_disabled();
        t_uart();
        t_freeze();
        t_priority();
        t_channels();
        t_bounds();
        t_modes();
        conclude();
    end
endmodule
